//--- design/qeo_encoder_out.sv
/*
 * Differential two-phase position output with real-time, burst and error
 * modes, alarm waveform and optional origin mark.
 * Assumes step, direction and fault levels come from detection logic on the
 * same clock, at most one step per cycle.
 */
`timescale 1ns/1ps

// Contract
// - Phase A and phase B square waves are a quarter period apart, each a complementary pair.
// - Retracting motion makes phase A lead phase B, advancing makes B lead.
// - Real-time edges follow motion at least the real-time gap apart and lag at most 1 us.
// - At the real-time speed limit the output switches to burst edges with the shorter gap.
// - Burst output lags at most 5 us one way or 10 us with a reversal.
// - Burst edges keep the accumulated count correct while burst output lasts.
// - Past the burst limit the output enters error mode with A and B in step.
// - Overspeed beyond response speed or a disturbed signal enters error mode.
// - Error mode pulses are at least the error-mode minimum width.
// - The fine variant uses only real-time and error modes.
// - The origin variant drives a differential origin pulse over a window near the reference.
// - An alarm replaces quadrature with a distinct waveform on the position lines.
// - An optional seventh line carries the alarm separately.
// - Error output edges are never narrower than 0.2 us; the entry edge into error mode can follow a quadrature edge by one cycle.
module qeo_encoder_out #(
    parameter bit TWO_MODE       = 1'b0,
    parameter bit HAS_ORIGIN     = 1'b1,
    parameter bit HAS_ALARM_LINE = 1'b1,
    parameter int STEP_NM        = 1000,
    parameter int POS_W          = 24
) (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              step_i,
    input  wire logic              retract_i,
    input  wire logic              over_rt_speed_i,
    input  wire logic              over_resp_speed_i,
    input  wire logic              disturb_i,
    input  wire logic              alarm_i,
    output qeo_pkg::qeo_pins_t     pins_o,
    output qeo_pkg::qeo_mode_t     mode_o
);

    localparam int HALF_WIN = qeo_pkg::ORIGIN_WIN_NM / 2 / STEP_NM;
    localparam int GAP_W    = $clog2(qeo_pkg::TR_CYC + 1);

    qeo_pkg::qeo_mode_t mode_q;
    qeo_pkg::qeo_pins_t pins_q;
    qeo_pkg::qeo_pins_t pins_d;
    logic signed [7:0]       pend_q;
    logic signed [7:0]       pend_d;
    logic [7:0]              pend_abs;
    logic [1:0]              phase_q;
    logic [GAP_W-1:0]        gap_q;
    logic [GAP_W-1:0]        gap_len;
    logic [2:0]              err_cnt_q;
    logic                    err_ph_q;
    logic                    err_tog_q;
    logic signed [POS_W-1:0] pos_q;
    logic                    fault;
    logic                    edge_go;
    logic                    in_win;

    // Count backlog magnitude
    assign pend_abs = pend_q[7] ? 8'(-pend_q) : 8'(pend_q);

    // Fault sources and burst overflow
    always_comb begin
        fault = over_resp_speed_i || disturb_i;
        if (mode_q == qeo_pkg::QEO_MODE_BURST
            && pend_abs > 8'(qeo_pkg::BURST_MAX_PEND)) begin
            fault = 1'b1;
        end
        if (TWO_MODE && pend_abs > 8'(qeo_pkg::RT_MAX_PEND)) begin
            fault = 1'b1;
        end
    end

    // One edge per gap while a backlog remains
    assign gap_len = (mode_q == qeo_pkg::QEO_MODE_BURST)
                     ? GAP_W'(qeo_pkg::TB_CYC) : GAP_W'(qeo_pkg::TR_CYC);
    assign edge_go = (pend_q != 8'sh00) && (gap_q == '0) && !alarm_i
                     && (mode_q != qeo_pkg::QEO_MODE_ERR);

    // Backlog of steps not yet shown on the lines
    always_comb begin
        pend_d = pend_q;
        if (step_i) begin
            pend_d = retract_i ? 8'(pend_d + 8'sh01)
                               : 8'(pend_d - 8'sh01);
        end
        if (edge_go) begin
            pend_d = pend_q[7] ? 8'(pend_d + 8'sh01)
                               : 8'(pend_d - 8'sh01);
        end
        if (mode_q == qeo_pkg::QEO_MODE_ERR) begin
            pend_d = qeo_pkg::PEND_RST;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend_q <= qeo_pkg::PEND_RST;
        end else begin
            pend_q <= pend_d;
        end
    end

    // Edge spacing counter
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_q <= '0;
        end else if (edge_go) begin
            gap_q <= GAP_W'(gap_len - 1'b1);
        end else if (gap_q != '0) begin
            gap_q <= GAP_W'(gap_q - 1'b1);
        end
    end

    // Quadrature phase, up when retracting
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_q <= qeo_pkg::PHASE_RST;
        end else if (mode_q == qeo_pkg::QEO_MODE_ERR) begin
            // Resume on the code whose lines match the error level
            phase_q <= {err_ph_q, 1'b0};
        end else if (edge_go) begin
            phase_q <= pend_q[7] ? 2'(phase_q - 2'h1)
                                 : 2'(phase_q + 2'h1);
        end
    end

    // Mode selection
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q <= qeo_pkg::QEO_MODE_RT;
        end else begin
            unique case (mode_q)
                qeo_pkg::QEO_MODE_RT: begin
                    if (fault) begin
                        mode_q <= qeo_pkg::QEO_MODE_ERR;
                    end else if (!TWO_MODE && (over_rt_speed_i
                             || pend_abs > 8'(qeo_pkg::RT_MAX_PEND))) begin
                        mode_q <= qeo_pkg::QEO_MODE_BURST;
                    end
                end
                qeo_pkg::QEO_MODE_BURST: begin
                    if (fault) begin
                        mode_q <= qeo_pkg::QEO_MODE_ERR;
                    end else if (!over_rt_speed_i && pend_q == 8'sh00) begin
                        mode_q <= qeo_pkg::QEO_MODE_RT;
                    end
                end
                qeo_pkg::QEO_MODE_ERR: begin
                    if (!over_resp_speed_i && !disturb_i
                        && err_cnt_q == 3'h0 && err_tog_q) begin
                        mode_q <= qeo_pkg::QEO_MODE_RT;
                    end
                end
                default: begin
                    mode_q <= qeo_pkg::QEO_MODE_ERR;
                end
            endcase
        end
    end

    // In-phase error toggling, each level held the error width
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            err_cnt_q <= 3'h0;
            err_ph_q  <= 1'b0;
            err_tog_q <= 1'b0;
        end else if (mode_q != qeo_pkg::QEO_MODE_ERR) begin
            err_cnt_q <= 3'(qeo_pkg::TE_CYC - 1);
            err_ph_q  <= phase_q[1];
            err_tog_q <= 1'b0;
        end else if (err_cnt_q == 3'h0) begin
            err_cnt_q <= 3'(qeo_pkg::TE_CYC - 1);
            err_ph_q  <= !err_ph_q;
            err_tog_q <= 1'b1;
        end else begin
            err_cnt_q <= 3'(err_cnt_q - 3'h1);
        end
    end

    // True position for the origin window
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pos_q <= '0;
        end else if (step_i) begin
            pos_q <= retract_i ? POS_W'(pos_q + 2'sb01)
                               : POS_W'(pos_q - 2'sb01);
        end
    end

    assign in_win = HAS_ORIGIN && (pos_q >= POS_W'(-HALF_WIN))
                    && (pos_q <= POS_W'(HALF_WIN));

    // Line levels
    always_comb begin
        pins_d.a_p = (phase_q == 2'h1) || (phase_q == 2'h2);
        pins_d.b_p = phase_q[1];
        if (mode_q == qeo_pkg::QEO_MODE_ERR) begin
            pins_d.a_p = err_ph_q;
            pins_d.b_p = err_ph_q;
        end
        if (alarm_i && !HAS_ALARM_LINE) begin
            pins_d.a_p = 1'b1;
            pins_d.b_p = 1'b0;
        end else if (alarm_i) begin
            pins_d.a_p = 1'b0;
            pins_d.b_p = 1'b0;
        end
        pins_d.a_n   = !pins_d.a_p;
        pins_d.b_n   = !pins_d.b_p;
        pins_d.z_p   = in_win;
        pins_d.z_n   = !in_win;
        pins_d.alarm = HAS_ALARM_LINE && alarm_i;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pins_q <= qeo_pkg::PINS_RST;
        end else begin
            pins_q <= pins_d;
        end
    end

    assign pins_o = pins_q;
    assign mode_o = mode_q;

    // Cycles since the last emitted edge
    logic [7:0] since_edge_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            since_edge_q <= 8'hff;
        end else if (edge_go) begin
            since_edge_q <= 8'h00;
        end else if (since_edge_q != 8'hff) begin
            since_edge_q <= 8'(since_edge_q + 8'h01);
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_pair_complement: assert property (
        pins_o.a_n == !pins_o.a_p && pins_o.b_n == !pins_o.b_p)
        else $error("Differential pair not complementary");

    a_retract_leads: assert property (
        edge_go && !pend_q[7] && mode_q != qeo_pkg::QEO_MODE_ERR
        |=> phase_q == 2'($past(phase_q) + 2'h1))
        else $error("Retract step did not advance phase");

    a_rt_edge_gap: assert property (
        edge_go && mode_q == qeo_pkg::QEO_MODE_RT && since_edge_q != 8'hff
        && $past(mode_q) == qeo_pkg::QEO_MODE_RT
        |-> since_edge_q >= 8'(qeo_pkg::TR_CYC - 1))
        else $error("Real-time edges too close");

    a_burst_gap: assert property (
        edge_go && mode_q == qeo_pkg::QEO_MODE_BURST && since_edge_q != 8'hff
        |-> since_edge_q >= 8'(qeo_pkg::TB_CYC - 1))
        else $error("Burst edges too close");

    a_burst_backlog: assert property (
        mode_q == qeo_pkg::QEO_MODE_BURST
        |-> pend_abs <= 8'(qeo_pkg::BURST_MAX_PEND + 1))
        else $error("Burst backlog over lag bound");

    a_burst_drains: assert property (
        mode_q == qeo_pkg::QEO_MODE_BURST && !step_i && pend_q != 8'sh00
        && gap_q == '0 && !alarm_i && !fault
        |=> pend_abs == 8'($past(pend_abs) - 8'h01))
        else $error("Burst edge did not reduce backlog");

    a_err_in_step: assert property (
        mode_q == qeo_pkg::QEO_MODE_ERR && !alarm_i
        |=> pins_o.a_p == pins_o.b_p)
        else $error("Error mode phases not in step");

    a_fault_enters: assert property (
        (disturb_i || over_resp_speed_i)
        && mode_q != qeo_pkg::QEO_MODE_ERR
        |=> mode_q == qeo_pkg::QEO_MODE_ERR)
        else $error("Fault did not enter error mode");

    a_err_width: assert property (
        mode_q == qeo_pkg::QEO_MODE_ERR && $changed(err_ph_q)
        |=> $stable(err_ph_q) [*3])
        else $error("Error pulse too narrow");

    a_two_mode: assert property (
        TWO_MODE |-> mode_q != qeo_pkg::QEO_MODE_BURST)
        else $error("Burst mode in two-mode variant");

    a_origin_pulse: assert property (
        in_win |=> pins_o.z_p && !pins_o.z_n)
        else $error("Origin pulse missing in window");

    a_alarm_wave: assert property (
        alarm_i |=> !pins_o.b_p && pins_o.alarm == HAS_ALARM_LINE)
        else $error("Alarm waveform missing");

    c_burst_entry: cover property (
        mode_q == qeo_pkg::QEO_MODE_RT ##1 mode_q == qeo_pkg::QEO_MODE_BURST);
    c_err_entry: cover property (
        mode_q == qeo_pkg::QEO_MODE_BURST ##1 mode_q == qeo_pkg::QEO_MODE_ERR);
    c_err_exit: cover property (
        mode_q == qeo_pkg::QEO_MODE_ERR ##1 mode_q == qeo_pkg::QEO_MODE_RT);
    c_origin: cover property (!in_win ##1 in_win);

endmodule : qeo_encoder_out

//--- dv/qeo_encoder_out_tb.sv
/*
 * Self-checking bench of the encoder output against a position model.
 * Assumes the receiver model and a 20 MHz clock.
 */
`timescale 1ns/1ps
module qeo_encoder_out_tb;
    localparam int HALF = qeo_pkg::ORIGIN_WIN_NM / 2 / 1000;
    logic               clk_i = 1'b0;
    logic               reset_n_i = 1'b0;
    logic               step_i = 1'b0;
    logic               retract_i = 1'b0;
    logic [2:0]         flt = 3'h0;
    logic               alarm_i = 1'b0;
    logic               clr = 1'b0;
    logic               err;
    logic               rt_only = 1'b0;
    logic               skip = 1'b0;
    logic [1:0]         ab_q = 2'h0;
    logic [31:0]        seed = 32'hc22f;
    qeo_pkg::qeo_pins_t pins;
    qeo_pkg::qeo_pins_t fine_pins;
    qeo_pkg::qeo_mode_t mode;
    qeo_pkg::qeo_mode_t fine_mode;
    qeo_pkg::qeo_mode_t lm = qeo_pkg::QEO_MODE_RT;
    int                 count;
    int                 pos = 0;
    int                 base = 0;
    int                 cyc = 0;
    int                 last_edge = 0;
    int                 err_run = 0;
    int                 gmin;
    int                 bad_count = 0;
    int                 cmp_count = 0;

    qeo_encoder_out #(.STEP_NM(1000)) u_dut (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .step_i(step_i), .retract_i(retract_i),
        .over_rt_speed_i(flt[0]), .over_resp_speed_i(flt[1]),
        .disturb_i(flt[2]), .alarm_i(alarm_i), .pins_o(pins), .mode_o(mode));
    qeo_encoder_out #(.TWO_MODE(1'b1), .HAS_ALARM_LINE(1'b0)) u_fine (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i), .step_i(step_i), .retract_i(retract_i),
        .over_rt_speed_i(flt[0]), .over_resp_speed_i(flt[1]),
        .disturb_i(flt[2]), .alarm_i(alarm_i), .pins_o(fine_pins),
        .mode_o(fine_mode));
    qeo_rx_model u_rx (.clk_i(clk_i), .reset_n_i(reset_n_i), .clr_i(clr),
        .pins_i(pins), .count_o(count), .err_o(err));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic qeo_pkg::qeo_pins_t mk(logic al);
        logic [1:0] i;
        logic       a;
        logic       b;
        logic       z;
        i = 2'(pos);
        a = !al && (i == 2'h1 || i == 2'h2);
        b = !al && i[1];
        z = pos >= -HALF && pos <= HALF;
        return '{a_p: a, a_n: !a, b_p: b, b_n: !b, z_p: z, z_n: !z,
                 alarm: al};
    endfunction : mk

    task automatic tally(logic ok, logic [31:0] g, logic [31:0] e);
        cmp_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : tally

    task automatic chk_pins(qeo_pkg::qeo_pins_t g, qeo_pkg::qeo_pins_t e);
        tally(g === e, 32'(g), 32'(e));
    endtask : chk_pins

    task automatic chk_mode(qeo_pkg::qeo_mode_t g, qeo_pkg::qeo_mode_t e);
        tally(g === e, 32'(g), 32'(e));
    endtask : chk_mode

    task automatic chk_flag(logic g, logic e);
        tally(g === e, 32'(g), 32'(e));
    endtask : chk_flag

    task automatic chk_num(int g, int e);
        tally(g == e, g, e);
    endtask : chk_num

    task automatic tick(int n);
        repeat (n) @(negedge clk_i);
    endtask : tick

    task automatic burst(int n, logic dir);
        step_i    = 1'b1;
        retract_i = dir;
        repeat (n) begin
            @(negedge clk_i);
            pos += dir ? 1 : -1;
        end
    endtask : burst

    task automatic walk(int n, logic dir, logic rd);
        repeat (n) begin
            burst(1, rd ? 1'(rnd()) : dir);
            step_i = 1'b0;
            tick(qeo_pkg::TR_CYC + 4 + rnd() % 8);
        end
        tick(qeo_pkg::RT_LAG_CYC);
    endtask : walk

    task automatic wait_mode(qeo_pkg::qeo_mode_t m, int n);
        for (int i = 0; i < n && mode !== m; i++) tick(1);
        chk_mode(mode, m);
    endtask : wait_mode

    task automatic rebase();
        clr = 1'b1;
        tick(1);
        clr  = 1'b0;
        base = pos;
    endtask : rebase

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // Line checks seen at the falling edge, where outputs are settled
    always @(negedge clk_i) begin
        if (reset_n_i) begin
            cyc <= cyc + 1;
            chk_flag(&{pins.a_n ^ pins.a_p, pins.b_n ^ pins.b_p,
                       pins.z_n ^ pins.z_p}, 1'b1);
            chk_flag(fine_mode !== qeo_pkg::QEO_MODE_BURST, 1'b1);
            err_run <= (mode == qeo_pkg::QEO_MODE_ERR) ? err_run + 1 : 0;
            if (err_run >= 2 && mode == qeo_pkg::QEO_MODE_ERR)
                chk_flag(pins.a_p, pins.b_p);
            gmin = (mode != lm) ? 0 :
                   (mode == qeo_pkg::QEO_MODE_ERR) ? qeo_pkg::TE_CYC :
                   (mode == qeo_pkg::QEO_MODE_BURST) ? qeo_pkg::TB_CYC :
                   rt_only ? qeo_pkg::TR_CYC : 0;
            if ({pins.a_p, pins.b_p} != ab_q) begin
                if (!skip)
                    chk_flag(cyc - last_edge >= gmin, 1'b1);
                last_edge <= cyc;
                lm        <= mode;
            end
            ab_q <= {pins.a_p, pins.b_p};
        end
    end

    initial begin
        #(20000 * 50);
        bad_count++;
        final_report();
    end

    initial begin
        tick(6);
        chk_pins(pins, qeo_pkg::PINS_RST);
        chk_mode(mode, qeo_pkg::QEO_MODE_RT);
        reset_n_i = 1'b1;
        burst(1, 1'b1);
        step_i = 1'b0;
        tick(1);
        chk_flag(pins.a_p, 1'b0);
        tick(1);
        chk_pins(pins, mk(1'b0));
        tick(qeo_pkg::TR_CYC);
        rt_only = 1'b1;
        walk(1, 1'b0, 1'b0);
        chk_pins(pins, mk(1'b0));
        walk(14, 1'b0, 1'b1);
        chk_pins(pins, mk(1'b0));
        chk_num(count, pos);
        walk(pos > HALF ? pos - HALF : HALF - pos, pos < HALF, 1'b0);
        chk_pins(pins, mk(1'b0));
        walk(1, 1'b1, 1'b0);
        chk_pins(pins, mk(1'b0));
        walk(HALF + 1, 1'b0, 1'b0);
        chk_pins(pins, mk(1'b0));
        rt_only = 1'b0;
        flt[0]  = 1'b1;
        tick(2);
        chk_mode(mode, qeo_pkg::QEO_MODE_BURST);
        burst(8, 1'b1);
        burst(5, 1'b0);
        step_i = 1'b0;
        tick(qeo_pkg::BURST_LAG2_CYC);
        chk_pins(pins, mk(1'b0));
        chk_num(count, pos);
        burst(9, 1'b0);
        step_i = 1'b0;
        tick(qeo_pkg::BURST_LAG1_CYC);
        chk_pins(pins, mk(1'b0));
        chk_mode(mode, qeo_pkg::QEO_MODE_BURST);
        flt[0] = 1'b0;
        wait_mode(qeo_pkg::QEO_MODE_RT, 40);
        skip    = 1'b1;
        alarm_i = 1'b1;
        tick(2);
        chk_pins(pins, mk(1'b1));
        chk_flag(fine_pins.a_p && !fine_pins.b_p, 1'b1);
        chk_flag(fine_pins.alarm, 1'b0);
        alarm_i = 1'b0;
        tick(10);
        skip = 1'b0;
        for (int k = 0; k < 3; k++) begin
            rebase();
            flt[k] = 1'b1;
            tick(2);
            if (k == 0) burst(14, 1'b1);
            step_i = 1'b0;
            wait_mode(qeo_pkg::QEO_MODE_ERR, 30);
            tick(20);
            chk_flag(err, 1'b1);
            flt = 3'h0;
            wait_mode(qeo_pkg::QEO_MODE_RT, 60);
            rebase();
            walk(5, 1'b1, 1'b1);
            chk_num(count, pos - base);
        end
        final_report();
    end
endmodule : qeo_encoder_out_tb

//--- dv/qeo_rx_model.sv
/*
 * Receiver model: decodes A/B into an up/down count, flags in-phase edges.
 * Assumes registered pins on the same clock as the encoder.
 */
`timescale 1ns/1ps
module qeo_rx_model (
    input  wire logic          clk_i,
    input  wire logic          reset_n_i,
    input  wire logic          clr_i,
    input  qeo_pkg::qeo_pins_t pins_i,
    output int                 count_o,
    output logic               err_o
);
    logic [1:0] prev_q;
    logic [1:0] cur;
    assign cur = {pins_i.a_p, pins_i.b_p};
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev_q  <= 2'h0;
            count_o <= 0;
            err_o   <= 1'b0;
        end else begin
            prev_q <= cur;
            if (clr_i) begin
                count_o <= 0;
                err_o   <= 1'b0;
            end else if (pins_i.alarm || (cur ^ prev_q) == 2'h3) begin
                err_o <= 1'b1;
            end else if (cur != prev_q && !err_o) begin
                count_o <= count_o + (((cur[1] != prev_q[1]) ==
                           (cur[1] != cur[0])) ? 1 : -1);
            end
        end
    end
endmodule : qeo_rx_model

//--- shared/qeo_pkg.sv
/*
 * Constants and types of the quadrature encoder output block.
 * Assumes a single 20 MHz clock; all times are turned into cycles here.
 */
package qeo_pkg;

    // Clock period
    localparam int CLK_PERIOD_NS = 50;

    // Minimum edge gaps and pulse width, in ns as printed
    localparam int REALTIME_MIN_EDGE_GAP_NS = 1000;
    localparam int BURST_MIN_EDGE_GAP_NS    = 500;
    localparam int ERROR_MIN_PULSE_WIDTH_NS = 200;

    // Output lag bounds, in ns
    localparam int RT_LAG_NS          = 1000;
    localparam int BURST_LAG_ONEWAY_NS = 5000;
    localparam int BURST_LAG_TWOWAY_NS = 10000;

    // Least times round up
    localparam int TR_CYC = (REALTIME_MIN_EDGE_GAP_NS + CLK_PERIOD_NS - 1)
                            / CLK_PERIOD_NS;
    localparam int TB_CYC = (BURST_MIN_EDGE_GAP_NS + CLK_PERIOD_NS - 1)
                            / CLK_PERIOD_NS;
    localparam int TE_CYC = (ERROR_MIN_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1)
                            / CLK_PERIOD_NS;

    // Longest times round down
    localparam int RT_LAG_CYC     = RT_LAG_NS / CLK_PERIOD_NS;
    localparam int BURST_LAG1_CYC = BURST_LAG_ONEWAY_NS / CLK_PERIOD_NS;
    localparam int BURST_LAG2_CYC = BURST_LAG_TWOWAY_NS / CLK_PERIOD_NS;

    // Largest backlog of edges that still meets each lag bound
    localparam int RT_MAX_PEND    = RT_LAG_CYC / TR_CYC;
    localparam int BURST_MAX_PEND = BURST_LAG1_CYC / TB_CYC;

    // Origin mark window, total width in nm
    localparam int ORIGIN_WIN_NM = 60000;

    // Reset values
    localparam logic [1:0] PHASE_RST = 2'h0;
    localparam logic [7:0] PEND_RST  = 8'h00;

    typedef enum logic [2:0] {
        QEO_MODE_RT    = 3'h1,
        QEO_MODE_BURST = 3'h2,
        QEO_MODE_ERR   = 3'h4
    } qeo_mode_t;

    // Line pins toward the receiver
    typedef struct packed {
        logic a_p;
        logic a_n;
        logic b_p;
        logic b_n;
        logic z_p;
        logic z_n;
        logic alarm;
    } qeo_pins_t;

    localparam qeo_pins_t PINS_RST = '{a_p: 1'b0, a_n: 1'b1, b_p: 1'b0,
                                       b_n: 1'b1, z_p: 1'b0, z_n: 1'b1,
                                       alarm: 1'b0};

endpackage : qeo_pkg
